// ===== design/keypad_lock_pkg.sv
// Constants, register map and state encoding for the keypad lock controller.
package keypad_lock_pkg;
    localparam logic [7:0] ADDR_FIRST = 8'h33;
    localparam logic [7:0] ADDR_SECOND = 8'h34;
    localparam logic [7:0] ADDR_TRIGGER = 8'h35;
    localparam logic [7:0] ADDR_TIMING = 8'h36;
    localparam logic [7:0] ADDR_CONTROL = 8'h37;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CONTROL_MASK = 8'h01;
    localparam int CODE_MSB = 6;
    localparam int POL_BIT = 7;
    localparam int LOCK_EN_BIT = 0;
    localparam int MASK_MSB = 7;
    localparam int MASK_LSB = 3;
    localparam int WIN_MSB = 2;
    localparam int SEC_W = 5;
    localparam logic [6:0] UNUSED_CODE = 7'h00;
    localparam int CORE_CLK_HZ = 50_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int CYCLES_PER_SEC = CORE_CLK_HZ * TICK_PERIOD_S;
    typedef enum logic [1:0] {
        ST_OPEN = 2'b00,
        ST_LOCKED = 2'b01,
        ST_FIRST = 2'b10
    } lock_state_t;
endpackage : keypad_lock_pkg

// ===== design/lock_timer_if.sv
// Control and status lines between the lock controller and a seconds timer.
`timescale 1ns/1ps
`default_nettype none
interface lock_timer_if;
    logic start;
    logic clear;
    logic [keypad_lock_pkg::SEC_W-1:0] secs;
    logic running;
    logic expired;
    modport ctrl (output start, output clear, output secs, input running, input expired);
    modport timer (input start, input clear, input secs, output running, output expired);
endinterface : lock_timer_if
`default_nettype wire

// ===== design/lock_sec_timer.sv
// Seconds countdown timer with its own one-second prescaler.
`timescale 1ns/1ps
`default_nettype none
module lock_sec_timer #(
    parameter int SEC_CYCLES = keypad_lock_pkg::CYCLES_PER_SEC
) (
    input wire logic core_clk,
    input wire logic rstN,
    lock_timer_if.timer tif
);
    localparam int CYC_W = $clog2(SEC_CYCLES);
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(SEC_CYCLES - 1);
    localparam logic [keypad_lock_pkg::SEC_W-1:0] SEC_ONE = 5'h01;

    generate
        if (SEC_CYCLES < 2) begin : gBadCycles
            $error("SEC_CYCLES must be at least 2");
        end
    endgenerate

    logic [CYC_W-1:0] cyc;
    logic [CYC_W-1:0] next_cyc;
    logic [keypad_lock_pkg::SEC_W-1:0] secLeft;
    logic [keypad_lock_pkg::SEC_W-1:0] next_secLeft;
    logic expired;
    logic next_expired;

    // A start restarts the prescaler so every duration is whole seconds.
    always_comb begin
        next_cyc = cyc;
        next_secLeft = secLeft;
        next_expired = 1'b0;
        if (tif.clear) begin
            next_cyc = '0;
            next_secLeft = '0;
        end else if (tif.start) begin
            next_cyc = '0;
            next_secLeft = tif.secs;
        end else if (secLeft != '0) begin
            if (cyc == CYC_LAST) begin
                next_cyc = '0;
                next_secLeft = secLeft - SEC_ONE;
                next_expired = (secLeft == SEC_ONE);
            end else begin
                next_cyc = cyc + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            cyc <= '0;
            secLeft <= '0;
            expired <= 1'b0;
        end else begin
            cyc <= next_cyc;
            secLeft <= next_secLeft;
            expired <= next_expired;
        end
    end

    assign tif.running = (secLeft != '0);
    assign tif.expired = expired;

    tick_period_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (secLeft != '0 && cyc == CYC_LAST && !tif.start && !tif.clear)
        |=> (secLeft == $past(secLeft) - SEC_ONE))
        else $error("Seconds count did not step at the end of a second.");
endmodule : lock_sec_timer
`default_nettype wire

// ===== design/keypad_lock_unlock.sv
// Keypad lock and unlock controller with its configuration registers.
`timescale 1ns/1ps
`default_nettype none
module keypad_lock_unlock #(
    parameter int SEC_CYCLES = keypad_lock_pkg::CYCLES_PER_SEC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic evtValid,
    input wire logic [6:0] evtCode,
    input wire logic evtState,
    input wire logic evtIsKey,
    output logic keypadLocked,
    output logic eventIntReq,
    output logic lockIntReq
);

    logic [1:0] rstPipe;
    logic rstN;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    // True when a programmed event field names the incoming event.
    function automatic logic eventMatch(input logic [7:0] field, input logic [6:0] code,
                                        input logic state, input logic isKey);
        logic pol;
        pol = field[keypad_lock_pkg::POL_BIT];
        eventMatch = (field[keypad_lock_pkg::CODE_MSB:0] != keypad_lock_pkg::UNUSED_CODE)
            && (field[keypad_lock_pkg::CODE_MSB:0] == code)
            && (pol == state)
            && !(isKey && !pol);
    endfunction : eventMatch

    logic [7:0] firstCode;
    logic [7:0] secondCode;
    logic [7:0] triggerCode;
    logic [7:0] timing;
    logic [7:0] control;
    logic [7:0] next_firstCode;
    logic [7:0] next_secondCode;
    logic [7:0] next_triggerCode;
    logic [7:0] next_timing;
    logic [7:0] next_control;
    logic [7:0] next_regRdata;

    always_comb begin
        next_firstCode = firstCode;
        next_secondCode = secondCode;
        next_triggerCode = triggerCode;
        next_timing = timing;
        next_control = control;
        if (regWrite) begin
            case (regAddr)
                keypad_lock_pkg::ADDR_FIRST: next_firstCode = regWdata;
                keypad_lock_pkg::ADDR_SECOND: next_secondCode = regWdata;
                keypad_lock_pkg::ADDR_TRIGGER: next_triggerCode = regWdata;
                keypad_lock_pkg::ADDR_TIMING: next_timing = regWdata;
                keypad_lock_pkg::ADDR_CONTROL:
                    next_control = regWdata & keypad_lock_pkg::CONTROL_MASK;
                default: next_control = control;
            endcase
        end
        next_regRdata = regRdata;
        if (regRead) begin
            case (regAddr)
                keypad_lock_pkg::ADDR_FIRST: next_regRdata = firstCode;
                keypad_lock_pkg::ADDR_SECOND: next_regRdata = secondCode;
                keypad_lock_pkg::ADDR_TRIGGER: next_regRdata = triggerCode;
                keypad_lock_pkg::ADDR_TIMING: next_regRdata = timing;
                keypad_lock_pkg::ADDR_CONTROL: next_regRdata = control;
                default: next_regRdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            firstCode <= keypad_lock_pkg::REG_RESET;
            secondCode <= keypad_lock_pkg::REG_RESET;
            triggerCode <= keypad_lock_pkg::REG_RESET;
            timing <= keypad_lock_pkg::REG_RESET;
            control <= keypad_lock_pkg::REG_RESET;
            regRdata <= 8'h00;
        end else begin
            firstCode <= next_firstCode;
            secondCode <= next_secondCode;
            triggerCode <= next_triggerCode;
            timing <= next_timing;
            control <= next_control;
            regRdata <= next_regRdata;
        end
    end

    lock_timer_if maskTif ();
    lock_timer_if winTif ();

    lock_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) uMaskTimer (
        .core_clk(core_clk),
        .rstN(rstN),
        .tif(maskTif)
    );
    lock_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) uWinTimer (
        .core_clk(core_clk),
        .rstN(rstN),
        .tif(winTif)
    );

    logic lockEn;
    logic lockEnPrev;
    logic hitFirst;
    logic hitSecond;
    logic hitTrigger;
    logic [4:0] maskSecs;
    logic [2:0] winSecs;
    keypad_lock_pkg::lock_state_t state;
    keypad_lock_pkg::lock_state_t next_state;
    logic next_keypadLocked;
    logic next_eventIntReq;
    logic next_lockIntReq;

    assign lockEn = control[keypad_lock_pkg::LOCK_EN_BIT];
    assign maskSecs = timing[keypad_lock_pkg::MASK_MSB:keypad_lock_pkg::MASK_LSB];
    assign winSecs = timing[keypad_lock_pkg::WIN_MSB:0];
    assign hitFirst = eventMatch(firstCode, evtCode, evtState, evtIsKey);
    assign hitSecond = eventMatch(secondCode, evtCode, evtState, evtIsKey);
    assign hitTrigger = eventMatch(triggerCode, evtCode, evtState, evtIsKey);

    always_comb begin
        next_state = state;
        next_lockIntReq = 1'b0;
        next_eventIntReq = evtValid;
        maskTif.start = 1'b0;
        maskTif.clear = 1'b0;
        maskTif.secs = maskSecs;
        winTif.start = 1'b0;
        winTif.clear = 1'b0;
        winTif.secs = {2'b00, winSecs};
        if (!lockEn) begin
            next_state = keypad_lock_pkg::ST_OPEN;
            maskTif.clear = 1'b1;
            winTif.clear = 1'b1;
        end else begin
            if (state != keypad_lock_pkg::ST_OPEN) begin
                // Locked: one interrupt per mask period, none when the mask time is zero.
                next_eventIntReq = evtValid && (maskSecs != 5'h00)
                    && !maskTif.running;
                maskTif.start = next_eventIntReq;
            end
            case (state)
                keypad_lock_pkg::ST_OPEN: begin
                    if (!lockEnPrev) begin
                        next_state = keypad_lock_pkg::ST_LOCKED;
                    end else if (evtValid && hitTrigger) begin
                        next_state = keypad_lock_pkg::ST_LOCKED;
                        next_lockIntReq = 1'b1;
                    end
                end
                keypad_lock_pkg::ST_LOCKED: begin
                    if (evtValid && hitTrigger) begin
                        next_lockIntReq = 1'b1;
                    end else if (evtValid && hitFirst) begin
                        next_state = keypad_lock_pkg::ST_FIRST;
                        winTif.start = 1'b1;
                    end
                end
                keypad_lock_pkg::ST_FIRST: begin
                    if (evtValid) begin
                        winTif.clear = 1'b1;
                        if (hitSecond) begin
                            next_state = keypad_lock_pkg::ST_OPEN;
                            maskTif.start = 1'b0;
                            maskTif.clear = 1'b1;
                        end else begin
                            next_state = keypad_lock_pkg::ST_LOCKED;
                            next_lockIntReq = hitTrigger;
                        end
                    end else if (winTif.expired) begin
                        next_state = keypad_lock_pkg::ST_LOCKED;
                    end
                end
                default: next_state = keypad_lock_pkg::ST_LOCKED;
            endcase
        end
        next_keypadLocked = (next_state != keypad_lock_pkg::ST_OPEN);
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state <= keypad_lock_pkg::ST_OPEN;
            lockEnPrev <= 1'b0;
            keypadLocked <= 1'b0;
            eventIntReq <= 1'b0;
            lockIntReq <= 1'b0;
        end else begin
            state <= next_state;
            lockEnPrev <= lockEn;
            keypadLocked <= next_keypadLocked;
            eventIntReq <= next_eventIntReq;
            lockIntReq <= next_lockIntReq;
        end
    end

    logic cfgStable;
    assign cfgStable = lockEn && !(regWrite && regAddr == keypad_lock_pkg::ADDR_CONTROL);

    sequence lockedPermit;
        cfgStable && state != keypad_lock_pkg::ST_OPEN && evtValid
            && maskSecs != 5'h00 && !maskTif.running
            && !(state == keypad_lock_pkg::ST_FIRST && hitSecond);
    endsequence
    sequence intThenMask;
        eventIntReq && maskTif.running ##1 !eventIntReq;
    endsequence

    disabled_open_a: assert property (@(posedge core_clk) disable iff (!rstN)
        !lockEn |=> !keypadLocked)
        else $error("Keypad locked while the lock function is off.");
    first_advance_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && state == keypad_lock_pkg::ST_LOCKED && evtValid && hitFirst && !hitTrigger)
        |=> state == keypad_lock_pkg::ST_FIRST)
        else $error("First release event did not advance the unlock sequence.");
    second_unlock_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && state == keypad_lock_pkg::ST_FIRST && evtValid && hitSecond)
        |=> !keypadLocked && state == keypad_lock_pkg::ST_OPEN)
        else $error("Second release event did not unlock the keypad.");
    release_ignored_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (evtValid && evtIsKey && !evtState) |-> !hitFirst && !hitSecond && !hitTrigger)
        else $error("A key release matched an event field.");
    gpi_polarity_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (evtValid && !evtIsKey)
        |-> (!hitFirst || evtState == firstCode[keypad_lock_pkg::POL_BIT])
            && (!hitSecond || evtState == secondCode[keypad_lock_pkg::POL_BIT]))
        else $error("GPI event matched with the wrong transition.");
    lock_flag_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && lockEnPrev && evtValid && hitTrigger
            && !(state == keypad_lock_pkg::ST_FIRST && hitSecond))
        |=> lockIntReq && keypadLocked ##1 !lockIntReq)
        else $error("Lock trigger did not lock the keypad and flag it.");
    permit_mask_a: assert property (@(posedge core_clk) disable iff (!rstN)
        lockedPermit |=> intThenMask)
        else $error("Permitted event did not interrupt and start the mask timer.");
    mask_suppress_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && state != keypad_lock_pkg::ST_OPEN && maskTif.running && evtValid)
        |=> !eventIntReq)
        else $error("Event interrupt raised while masked.");
    window_expire_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && state == keypad_lock_pkg::ST_FIRST && !evtValid && winTif.expired)
        |=> state == keypad_lock_pkg::ST_LOCKED)
        else $error("Unlock window expiry did not relock the keypad.");
    other_event_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && state == keypad_lock_pkg::ST_FIRST && evtValid && !hitSecond)
        |=> state == keypad_lock_pkg::ST_LOCKED)
        else $error("Stray event did not return full lock.");
    zero_code_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (evtValid && evtCode == keypad_lock_pkg::UNUSED_CODE)
        |-> !hitFirst && !hitSecond && !hitTrigger)
        else $error("An unused code field matched an event.");
    enable_lock_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (lockEn && !lockEnPrev) |=> keypadLocked)
        else $error("Enabling the lock function did not lock the keypad.");
    control_read_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (regRead && regAddr == keypad_lock_pkg::ADDR_CONTROL)
        |=> regRdata == $past(control))
        else $error("Lock control read back a wrong value.");
    trigger_hold_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && state == keypad_lock_pkg::ST_LOCKED && evtValid && hitTrigger)
        |=> keypadLocked && lockIntReq && state == keypad_lock_pkg::ST_LOCKED)
        else $error("Lock trigger while locked did not flag and hold the lock.");
    unlock_unmask_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && state == keypad_lock_pkg::ST_FIRST && evtValid && hitSecond)
        |=> !maskTif.running)
        else $error("Unlocking did not end the interrupt mask time.");
    window_start_a: assert property (@(posedge core_clk) disable iff (!rstN)
        (cfgStable && state == keypad_lock_pkg::ST_LOCKED && evtValid && hitFirst && !hitTrigger)
        |=> winTif.running == ($past(winSecs) != 3'h0))
        else $error("Unlock window did not start with the programmed time.");
endmodule : keypad_lock_unlock
`default_nettype wire

// ===== testbench/event_source_model.sv
// Behavioural model of the key scanner and the GPI/logic event queue feeding the lock block.
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
    input wire logic core_clk,
    output var logic evtValid,
    output var logic [6:0] evtCode,
    output var logic evtState,
    output var logic evtIsKey
);
    initial begin
        evtValid = 1'b0;
        evtCode = 7'h55;
        evtState = 1'b0;
        evtIsKey = 1'b0;
    end

    // Presents one event for a single cycle.
    // Afterwards the qualifiers show the inverse of the last value, so a stale code never matches.
    task automatic send(input logic [6:0] code, input logic state, input logic isKey);
        @(posedge core_clk);
        evtValid <= 1'b1;
        evtCode <= code;
        evtState <= state;
        evtIsKey <= isKey;
        @(posedge core_clk);
        evtValid <= 1'b0;
        evtCode <= ~code;
        evtState <= ~state;
        evtIsKey <= ~isKey;
    endtask : send
endmodule : event_source_model
`default_nettype wire

// ===== testbench/keypad_lock_unlock_bench.sv
// Self-checking testbench for the keypad lock and unlock controller.
`timescale 1ns/1ps
`default_nettype none
module keypad_lock_unlock_bench;
    localparam int SEC = 20;
    logic core_clk;
    logic nrst;
    logic [7:0] regAddr;
    logic regWrite;
    logic regRead;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic evtValid;
    logic [6:0] evtCode;
    logic evtState;
    logic evtIsKey;
    logic keypadLocked;
    logic eventIntReq;
    logic lockIntReq;
    int nMismatch = 0;
    int nTests = 0;
    int cycles = 0;

    keypad_lock_unlock #(.SEC_CYCLES(SEC)) keypad_lock_unlock_inst (
        .core_clk(core_clk),
        .nrst(nrst),
        .regAddr(regAddr),
        .regWrite(regWrite),
        .regRead(regRead),
        .regWdata(regWdata),
        .regRdata(regRdata),
        .evtValid(evtValid),
        .evtCode(evtCode),
        .evtState(evtState),
        .evtIsKey(evtIsKey),
        .keypadLocked(keypadLocked),
        .eventIntReq(eventIntReq),
        .lockIntReq(lockIntReq)
    );

    event_source_model event_source_model_inst (
        .core_clk(core_clk),
        .evtValid(evtValid),
        .evtCode(evtCode),
        .evtState(evtState),
        .evtIsKey(evtIsKey)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // The whole run needs well under a thousand cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            nMismatch++;
            end_sim();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd

    // Sends one event and returns just after the edge that answers it.
    task automatic ev(input logic [6:0] c, input logic s, input logic k);
        event_source_model_inst.send(c, s, k);
        #1;
    endtask : ev

    task automatic relock();
        wr(keypad_lock_pkg::ADDR_CONTROL, 8'h00);
        wr(keypad_lock_pkg::ADDR_CONTROL, 8'h01);
        @(posedge core_clk);
        #1 chk1(keypadLocked, 1'b1);
    endtask : relock

    task automatic unlock();
        ev(7'h05, 1'b1, 1'b1);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b0);
    endtask : unlock

    task automatic t_regs();
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            rd(keypad_lock_pkg::ADDR_FIRST + 8'(i), d);
            chk8(d, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            wr(keypad_lock_pkg::ADDR_FIRST + 8'(i), 8'h5A + 8'(i));
            rd(keypad_lock_pkg::ADDR_FIRST + 8'(i), d);
            chk8(d, 8'h5A + 8'(i));
        end
        wr(keypad_lock_pkg::ADDR_CONTROL, 8'hFF);
        rd(keypad_lock_pkg::ADDR_CONTROL, d);
        chk8(d, 8'h01);
        wr(8'h38, 8'hFF);
        rd(8'h38, d);
        chk8(d, 8'h00);
        wr(keypad_lock_pkg::ADDR_FIRST, 8'h85);
        wr(keypad_lock_pkg::ADDR_SECOND, 8'h12);
        wr(keypad_lock_pkg::ADDR_TRIGGER, 8'hA1);
        wr(keypad_lock_pkg::ADDR_TIMING, 8'h02);
    endtask : t_regs

    task automatic t_unlock();
        relock();
        ev(7'h05, 1'b1, 1'b1);
        chk1(keypadLocked, 1'b1);
        chk1(eventIntReq, 1'b0);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b0);
    endtask : t_unlock

    task automatic t_order();
        relock();
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b1);
        ev(7'h05, 1'b0, 1'b1);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b1);
        ev(7'h05, 1'b1, 1'b1);
        ev(7'h12, 1'b1, 1'b0);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b1);
        ev(7'h05, 1'b1, 1'b1);
        ev(7'h40, 1'b1, 1'b1);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b1);
    endtask : t_order

    task automatic t_window();
        wr(keypad_lock_pkg::ADDR_TIMING, 8'h01);
        relock();
        ev(7'h05, 1'b1, 1'b1);
        repeat (SEC + 10) @(posedge core_clk);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b1);
        ev(7'h05, 1'b1, 1'b1);
        repeat (SEC - 10) @(posedge core_clk);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b0);
        wr(keypad_lock_pkg::ADDR_TIMING, 8'h00);
        relock();
        ev(7'h05, 1'b1, 1'b1);
        repeat (5 * SEC) @(posedge core_clk);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b0);
    endtask : t_window

    task automatic t_trigger();
        ev(7'h21, 1'b1, 1'b1);
        chk1(lockIntReq, 1'b1);
        chk1(keypadLocked, 1'b1);
        @(posedge core_clk);
        #1 chk1(lockIntReq, 1'b0);
        unlock();
        wr(keypad_lock_pkg::ADDR_TRIGGER, 8'h21);
        ev(7'h21, 1'b1, 1'b0);
        chk1(lockIntReq, 1'b0);
        chk1(keypadLocked, 1'b0);
        ev(7'h21, 1'b0, 1'b0);
        chk1(lockIntReq, 1'b1);
        chk1(keypadLocked, 1'b1);
    endtask : t_trigger

    task automatic t_mask();
        wr(keypad_lock_pkg::ADDR_TIMING, 8'h08);
        relock();
        ev(7'h40, 1'b1, 1'b0);
        chk1(eventIntReq, 1'b1);
        ev(7'h41, 1'b1, 1'b1);
        chk1(eventIntReq, 1'b0);
        repeat (SEC + 10) @(posedge core_clk);
        ev(7'h40, 1'b1, 1'b0);
        chk1(eventIntReq, 1'b1);
        wr(keypad_lock_pkg::ADDR_FIRST, 8'h80);
        wr(keypad_lock_pkg::ADDR_SECOND, 8'h86);
        relock();
        ev(7'h00, 1'b1, 1'b1);
        ev(7'h06, 1'b1, 1'b1);
        chk1(keypadLocked, 1'b1);
    endtask : t_mask

    // Unlock must end the mask time; triggers while locked and mid-sequence must flag.
    task automatic t_lockint();
        wr(keypad_lock_pkg::ADDR_FIRST, 8'h85);
        wr(keypad_lock_pkg::ADDR_SECOND, 8'h12);
        relock();
        ev(7'h05, 1'b1, 1'b1);
        chk1(eventIntReq, 1'b1);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b0);
        chk1(eventIntReq, 1'b0);
        ev(7'h21, 1'b0, 1'b0);
        chk1(lockIntReq, 1'b1);
        chk1(eventIntReq, 1'b1);
        ev(7'h40, 1'b1, 1'b0);
        chk1(eventIntReq, 1'b1);
        ev(7'h21, 1'b0, 1'b0);
        chk1(lockIntReq, 1'b1);
        chk1(keypadLocked, 1'b1);
        chk1(eventIntReq, 1'b0);
        ev(7'h05, 1'b1, 1'b1);
        ev(7'h21, 1'b0, 1'b0);
        chk1(lockIntReq, 1'b1);
        ev(7'h12, 1'b0, 1'b0);
        chk1(keypadLocked, 1'b1);
    endtask : t_lockint

    // A reset in mid-run must drop the lock and clear the registers.
    task automatic t_reset();
        logic [7:0] d;
        @(posedge core_clk);
        nrst <= 1'b0;
        @(posedge core_clk);
        #1 chk1(keypadLocked, 1'b0);
        @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(keypad_lock_pkg::ADDR_CONTROL, d);
        chk8(d, 8'h00);
        rd(keypad_lock_pkg::ADDR_FIRST, d);
        chk8(d, 8'h00);
        chk1(keypadLocked, 1'b0);
    endtask : t_reset

    initial begin
        nrst = 1'b0;
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_unlock();
        t_order();
        t_window();
        t_trigger();
        t_mask();
        t_lockint();
        t_reset();
        end_sim();
    end
endmodule : keypad_lock_unlock_bench
`default_nettype wire
